// file: dp_host_pkg.sv
package dp_host_pkg;
   localparam int LANE_W = 9;
   localparam int LANES = 4;
   localparam int DATA_W = 36;
   localparam int ADDR_W = 15;
   // Own register offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h1;
   localparam logic [3:0] REG_WDATA = 4'h2;
   localparam logic [3:0] REG_RDATA = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_CMD = 4'h5;
   // CTRL fields
   localparam int CTRL_BM_BIT = 0;
   localparam int CTRL_SIZE_BIT = 1;
   localparam int CTRL_LANES_LSB = 2;
   localparam logic [5:0] CTRL_RESET = 6'h3C;
   // CMD fields
   localparam int CMD_WRITE_BIT = 0;
   localparam int CMD_SEM_BIT = 1;
   localparam int CMD_WA_BIT = 2;
   localparam int CMD_BA_BIT = 3;
   // Timing: strobe and clock in ns, converted to cycles
   localparam int STROBE_NS = 30;
   localparam int CLK_NS = 10;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETTLE_CYC = 1;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SETUP = 2'b01,
      ST_STROBE = 2'b10,
      ST_DONE = 2'b11
   } state_t;
endpackage

// file: dp_host.sv
// Functional notes
// - Bus-match and size settle at least one cycle before access.
// - Bus-match select held constant while operating.
// - Bus-size select held constant during normal operation.
// - Word select is an address bit with address timing.
// - Word and byte select are address bits with address timing.
// - Ignored and unused inputs are driven firmly, never floating; here unused data lines float in word, byte and I/O disable modes.
`timescale 1ns/1ps
module dp_host #(
   parameter int ADDR_W = dp_host_pkg::ADDR_W
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output logic bus_match_select,
   output logic bus_size_select,
   output logic lane0_control_n,
   output logic lane1_control_n,
   output logic lane2_control_n,
   output logic lane3_control_n,
   output logic chip_enable_n,
   output logic read_write_n,
   output logic output_enable_n,
   output logic semaphore_access_select_n,
   output logic [ADDR_W-1:0] mem_addr,
   output logic word_half_select,
   output logic byte_select,
   input wire logic [35:0] data_in,
   output logic [35:0] data_out,
   output logic [35:0] data_oe
);
   logic rst_s1_q, rst_n_q;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   dp_host_pkg::state_t state_q, state_d;
   logic [5:0] ctrl_q, ctrl_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [35:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic [3:0] cmd_q, cmd_d;
   logic [3:0] cnt_q, cnt_d;
   logic settled_q, settled_d;
   logic busy;
   logic [1:0] mode;
   logic [35:0] oe_mask, out_vec, rd_vec;
   logic [3:0] lanes_n;

   assign busy = state_q != dp_host_pkg::ST_IDLE;
   assign mode = {ctrl_q[dp_host_pkg::CTRL_BM_BIT], ctrl_q[dp_host_pkg::CTRL_SIZE_BIT]};
   assign lanes_n = ctrl_q[dp_host_pkg::CTRL_LANES_LSB +: 4];

   // Packs data into right-port lines and builds the drive mask
   always_comb begin
      out_vec = wdata_q;
      oe_mask = '1;
      rd_vec = data_in;
      case (mode)
         2'b00: begin
            out_vec = wdata_q;
            oe_mask = '1;
            rd_vec = data_in;
         end
         // all right I/O disabled by device; we stay off too
         2'b01: begin
            out_vec = '0;
            oe_mask = '0;
            rd_vec = data_in;
         end
         // word half on lines 0-17, upper lines float
         2'b10: begin
            out_vec = {18'h0, cmd_q[dp_host_pkg::CMD_WA_BIT] ? wdata_q[35:18] : wdata_q[17:0]};
            oe_mask = {18'h0, 18'h3FFFF};
            rd_vec = cmd_q[dp_host_pkg::CMD_WA_BIT] ? {data_in[17:0], rdata_q[17:0]}
                                                     : {rdata_q[35:18], data_in[17:0]};
         end
         // byte group on lines 0-8, rest floats
         2'b11: begin
            out_vec = {27'h0, wdata_q[9*{cmd_q[dp_host_pkg::CMD_WA_BIT],
                                          cmd_q[dp_host_pkg::CMD_BA_BIT]} +: 9]};
            oe_mask = {27'h0, 9'h1FF};
            rd_vec = rdata_q;
            rd_vec[9*{cmd_q[dp_host_pkg::CMD_WA_BIT], cmd_q[dp_host_pkg::CMD_BA_BIT]} +: 9]
               = data_in[8:0];
         end
         default: begin
            out_vec = wdata_q;
            oe_mask = '1;
            rd_vec = data_in;
         end
      endcase
      // semaphore value sits on lines 0-8
      if (cmd_q[dp_host_pkg::CMD_SEM_BIT]) begin
         out_vec = {27'h0, wdata_q[8:0]};
         // semaphore path stays live in I/O disable mode
         oe_mask = {27'h0, 9'h1FF};
         rd_vec = {27'h0, data_in[8:0]};
      end
   end

   always_comb begin
      state_d = state_q;
      ctrl_d = ctrl_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      cmd_d = cmd_q;
      cnt_d = cnt_q;
      settled_d = 1'b1;
      if (reg_write && !busy) begin
         case (reg_addr)
            // mode changes force one settle cycle
            dp_host_pkg::REG_CTRL: begin
               ctrl_d = reg_wdata[5:0];
               settled_d = 1'b0;
            end
            dp_host_pkg::REG_ADDR: addr_d = reg_wdata[ADDR_W-1:0];
            // Lines 32-35 always written low: data register is 32 bits
            dp_host_pkg::REG_WDATA: wdata_d = {4'h0, reg_wdata};
            dp_host_pkg::REG_CMD: begin
               cmd_d = reg_wdata[3:0];
               cnt_d = '0;
               state_d = dp_host_pkg::ST_SETUP;
            end
            default: ;
         endcase
      end
      case (state_q)
         dp_host_pkg::ST_IDLE: ;
         // wait for mode settle before strobing
         dp_host_pkg::ST_SETUP: if (settled_q) begin
            state_d = dp_host_pkg::ST_STROBE;
         end
         dp_host_pkg::ST_STROBE: begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'(dp_host_pkg::STROBE_CYC - 1)) begin
               state_d = dp_host_pkg::ST_DONE;
               if (!cmd_q[dp_host_pkg::CMD_WRITE_BIT]) begin
                  rdata_d = rd_vec;
               end
            end
         end
         dp_host_pkg::ST_DONE: state_d = dp_host_pkg::ST_IDLE;
         default: state_d = dp_host_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= dp_host_pkg::ST_IDLE;
         ctrl_q <= dp_host_pkg::CTRL_RESET;
         addr_q <= '0;
         wdata_q <= '0;
         rdata_q <= '0;
         cmd_q <= '0;
         cnt_q <= '0;
         settled_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ctrl_q <= ctrl_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         cmd_q <= cmd_d;
         cnt_q <= cnt_d;
         settled_q <= settled_d;
      end
   end

   logic [31:0] rd_d, rd_q;
   always_comb begin
      rd_d = '0;
      if (reg_read) begin
         case (reg_addr)
            dp_host_pkg::REG_CTRL: rd_d = {26'h0, ctrl_q};
            dp_host_pkg::REG_ADDR: rd_d = 32'(addr_q);
            dp_host_pkg::REG_WDATA: rd_d = wdata_q[31:0];
            dp_host_pkg::REG_RDATA: rd_d = rdata_q[31:0];
            dp_host_pkg::REG_STATUS: begin
               rd_d = {26'h0, rdata_q[35:32], state_q == dp_host_pkg::ST_DONE, busy};
            end
            default: rd_d = '0;
         endcase
      end
   end
   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rd_q <= '0;
      end else begin
         rd_q <= rd_d;
      end
   end
   assign reg_rdata = rd_q;

   logic strobing, driving, write_hold;
   assign strobing = state_q == dp_host_pkg::ST_STROBE;
   assign driving = strobing && cmd_q[dp_host_pkg::CMD_WRITE_BIT];
   // Data kept a cycle past the write strobe: gives the far side hold time
   assign write_hold = state_q == dp_host_pkg::ST_DONE && cmd_q[dp_host_pkg::CMD_WRITE_BIT];
   assign bus_match_select = ctrl_q[dp_host_pkg::CTRL_BM_BIT];
   assign bus_size_select = ctrl_q[dp_host_pkg::CTRL_SIZE_BIT];
   // one control per 9-bit lane; each follows its CTRL lane bit, high after reset
   assign lane0_control_n = lanes_n[0];
   assign lane1_control_n = lanes_n[1];
   assign lane2_control_n = lanes_n[2];
   assign lane3_control_n = lanes_n[3];
   assign chip_enable_n = !(strobing && !cmd_q[dp_host_pkg::CMD_SEM_BIT]);
   assign semaphore_access_select_n = !(strobing && cmd_q[dp_host_pkg::CMD_SEM_BIT]);
   assign read_write_n = !driving;
   assign output_enable_n = !(strobing && !cmd_q[dp_host_pkg::CMD_WRITE_BIT]);
   // selects held as address bits, forced low when ignored
   assign mem_addr = busy ? addr_q : '0;
   assign word_half_select = busy && mode[1] && cmd_q[dp_host_pkg::CMD_WA_BIT];
   assign byte_select = busy && mode == 2'b11 && cmd_q[dp_host_pkg::CMD_BA_BIT];
   assign data_out = out_vec;
   assign data_oe = (driving || write_hold) ? oe_mask : '0;

   // no strobe in the cycle after a mode change
   settle_a: assert property (@(posedge clock) disable iff (!rst_n_q)
      !settled_q |-> !strobing)
      else $error("strobe in settle cycle");
   // upper lines never driven in word mode
   word_float_a: assert property (@(posedge clock) disable iff (!rst_n_q)
      mode == 2'b10 |-> data_oe[35:18] == 18'h0)
      else $error("upper lines driven in word mode");
   // only lines 0-8 driven in byte mode
   byte_float_a: assert property (@(posedge clock) disable iff (!rst_n_q)
      mode == 2'b11 |-> data_oe[35:9] == 27'h0)
      else $error("upper lines driven in byte mode");
   // no array data driven in disable mode
   io_off_a: assert property (@(posedge clock) disable iff (!rst_n_q)
      mode == 2'b01 && !cmd_q[dp_host_pkg::CMD_SEM_BIT] |-> data_oe == 36'h0)
      else $error("array data driven in disable mode");
   // byte select low outside byte mode
   ignore_sel_a: assert property (@(posedge clock) disable iff (!rst_n_q)
      mode != 2'b11 |-> !byte_select)
      else $error("byte select raised outside byte mode");
   // word select low in long-word mode
   word_sel_a: assert property (@(posedge clock) disable iff (!rst_n_q)
      !mode[1] |-> !word_half_select)
      else $error("word select raised in long-word mode");

   // Strobe window: rises, stands three cycles, then drops
   sequence strobe_start_s;
      $rose(strobing);
   endsequence
   sequence strobe_hold_s;
      strobing [*3] ##1 !strobing;
   endsequence
   strobe_len_a: assert property (@(posedge clock) disable iff (!rst_n_q)
      strobe_start_s |-> strobe_hold_s)
      else $error("strobe width wrong");
   addr_hold_a: assert property (@(posedge clock) disable iff (!rst_n_q)
      strobing |-> $stable(mem_addr) && $stable(word_half_select) && $stable(byte_select))
      else $error("address moved during strobe");

   // Write end: data must outlive the strobe
   sequence write_end_s;
      $fell(driving);
   endsequence
   data_hold_a: assert property (@(posedge clock) disable iff (!rst_n_q)
      write_end_s |-> data_oe == $past(data_oe))
      else $error("data released with write strobe");
   // semaphore data on lines 0-8 only
   sem_lanes_a: assert property (@(posedge clock) disable iff (!rst_n_q)
      !semaphore_access_select_n |-> data_oe[35:9] == 27'h0)
      else $error("semaphore drive beyond line 8");
   // mode pins steady during an access
   mode_stable_a: assert property (@(posedge clock) disable iff (!rst_n_q)
      busy |-> $stable(bus_match_select) && $stable(bus_size_select))
      else $error("mode pins moved during access");
   idle_quiet_a: assert property (@(posedge clock) disable iff (!rst_n_q)
      !busy |-> chip_enable_n && semaphore_access_select_n && read_write_n && output_enable_n)
      else $error("strobe active while idle");
endmodule

// file: dp_mem_model.sv
`timescale 1ns/1ps
module dp_mem_model (
   input wire logic bus_match_select,
   input wire logic bus_size_select,
   input wire logic [3:0] lane_n,
   input wire logic chip_enable_n,
   input wire logic read_write_n,
   input wire logic output_enable_n,
   input wire logic sem_n,
   input wire logic [4:0] addr,
   input wire logic wa,
   input wire logic ba,
   input wire logic [35:0] bus,
   output logic [35:0] drv,
   output logic [35:0] en
);
   logic [35:0] mem [0:31];
   logic sem_q = 1'h1;
   logic sem_rd = 1'h1;
   wire io_on = bus_match_select | ~bus_size_select;
   wire [5:0] bsel = 6'({wa, ba} * 9);
   always @* begin
      if (!chip_enable_n && !read_write_n && sem_n && io_on) begin
         if (!bus_match_select) begin
            for (int l = 0; l < 4; l++) begin
               if (!lane_n[l]) mem[addr][l*9+:9] = bus[l*9+:9];
            end
         end else if (!bus_size_select) begin
            mem[addr][(wa ? 18 : 0)+:18] = bus[17:0];
         end else begin
            mem[addr][bsel+:9] = bus[8:0];
         end
      end
   end
   always @* begin
      if (!sem_n && !read_write_n && chip_enable_n) sem_q = bus[0];
   end
   always @* begin
      if (!sem_n && output_enable_n) sem_rd = sem_q;
   end
   always @* begin
      drv = 36'h0;
      en = 36'h0;
      if (!output_enable_n && read_write_n) begin
         if (!sem_n) begin
            drv[8:0] = {9{sem_rd}};
            en[8:0] = 9'h1FF;
         end else if (!chip_enable_n && io_on) begin
            if (!bus_match_select) begin
               drv = mem[addr];
               en = {{9{~lane_n[3]}}, {9{~lane_n[2]}}, {9{~lane_n[1]}}, {9{~lane_n[0]}}};
            end else if (!bus_size_select) begin
               drv[17:0] = wa ? mem[addr][35:18] : mem[addr][17:0];
               en[17:0] = 18'h3FFFF;
            end else begin
               drv[8:0] = mem[addr][bsel+:9];
               en[8:0] = 9'h1FF;
            end
         end
      end
   end
endmodule

// file: dp_host_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin \
   compares++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
   end \
end
module dp_host_tb;
   logic clock = 1'h0;
   logic reset_n = 1'h0;
   logic reg_write = 1'h0;
   logic reg_read = 1'h0;
   logic noise = 1'h0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata, rd_v, w0, w1;
   logic bus_match_select, bus_size_select, chip_enable_n, read_write_n, output_enable_n;
   logic lane0_control_n, lane1_control_n, lane2_control_n, lane3_control_n;
   logic semaphore_access_select_n, word_half_select, byte_select;
   logic [14:0] mem_addr;
   logic [35:0] data_in, data_out, data_oe, dev_drv, dev_en, exp_m;
   logic [4:0] a;
   logic [8:0] b;
   int fails = 0;
   int compares = 0;
   // Released lines show a toggling pattern, not a stale value
   assign data_in = (dev_en & dev_drv) | (~dev_en & data_oe & data_out)
      | (~dev_en & ~data_oe & {36{noise}});
   dp_host #(.ADDR_W(15)) i_dut (.clock, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .bus_match_select, .bus_size_select, .lane0_control_n, .lane1_control_n,
      .lane2_control_n, .lane3_control_n, .chip_enable_n, .read_write_n, .output_enable_n,
      .semaphore_access_select_n, .mem_addr, .word_half_select, .byte_select, .data_in,
      .data_out, .data_oe);
   dp_mem_model i_dev (.bus_match_select, .bus_size_select, .chip_enable_n, .read_write_n,
      .lane_n({lane3_control_n, lane2_control_n, lane1_control_n, lane0_control_n}),
      .output_enable_n, .sem_n(semaphore_access_select_n), .addr(mem_addr[4:0]),
      .wa(word_half_select), .ba(byte_select), .bus(data_in), .drv(dev_drv), .en(dev_en));
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) noise <= ~noise;
   task automatic wrap_up;
      $display("Compares %0d, fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] ad, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge clock);
      reg_write <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] ad, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= ad;
      reg_read <= 1'h1;
      @(posedge clock);
      reg_read <= 1'h0;
      #1 d = reg_rdata;
   endtask
   task automatic go(input logic [3:0] cmd);
      logic [31:0] s;
      wr(dp_host_pkg::REG_CMD, {28'h0, cmd});
      repeat (2) @(posedge clock);
      for (int i = 0; i < 40; i++) begin
         rd(dp_host_pkg::REG_STATUS, s);
         if (s[0] === 1'h0) break;
      end
      `CHK(s[0], 1'h0)
   endtask
   task automatic acc(input logic [4:0] ad, input logic [31:0] d, input logic [3:0] cmd);
      wr(dp_host_pkg::REG_ADDR, {27'h0, ad});
      wr(dp_host_pkg::REG_WDATA, d);
      go(cmd);
   endtask
   // Settle gap so the next access starts after the settle cycle
   task automatic mode(input logic [5:0] c);
      wr(dp_host_pkg::REG_CTRL, {26'h0, c});
      repeat (3) @(posedge clock);
   endtask
   initial begin
      // Roughly twenty-five times the expected run length
      repeat (20000) @(posedge clock);
      fails++;
      wrap_up;
   end
   initial begin
      void'($urandom(27));
      repeat (16) @(posedge clock);
      reset_n <= 1'h1;
      repeat (4) @(posedge clock);
      for (int n = 0; n < 4; n++) begin
         a = 5'($urandom());
         w0 = $urandom();
         w1 = $urandom();
         mode(6'h00);
         acc(a, w0, 4'h1);
         `CHK(i_dev.mem[a][31:0], w0)
         go(4'hC);
         rd(dp_host_pkg::REG_RDATA, rd_v);
         `CHK(rd_v, w0)
         mode(6'h10);
         acc(a, w1, 4'h1);
         `CHK(i_dev.mem[a][31:0], {w1[31:27], w0[26:18], w1[17:0]})
         mode(6'h01);
         acc(a, w0, 4'h9);
         acc(a, w1, 4'h5);
         `CHK(i_dev.mem[a], {4'h0, w1[31:18], w0[17:0]})
         go(4'h8);
         rd(dp_host_pkg::REG_RDATA, rd_v);
         `CHK(rd_v[17:0], w0[17:0])
         go(4'h4);
         rd(dp_host_pkg::REG_RDATA, rd_v);
         `CHK(rd_v, {w1[31:18], w0[17:0]})
         mode(6'h03);
         for (int l = 0; l < 4; l++) begin
            b = 9'($urandom());
            // Lines 32-35 cannot be set through the 32-bit data register
            if (l == 3) b[8:5] = 4'h0;
            exp_m[l*9+:9] = b;
            acc(a, 32'({27'h0, b} << (9 * l)), {l[0], l[1], 2'h1});
         end
         `CHK(i_dev.mem[a], exp_m)
         go(4'h0);
         rd(dp_host_pkg::REG_RDATA, rd_v);
         `CHK(rd_v[8:0], exp_m[8:0])
         go(4'h4);
         rd(dp_host_pkg::REG_RDATA, rd_v);
         `CHK({rd_v[26:18], rd_v[8:0]}, {exp_m[26:18], exp_m[8:0]})
         mode(6'h02);
         acc(a, ~w0, 4'h1);
         `CHK(i_dev.mem[a], exp_m)
      end
      acc(5'h00, 32'h0, 4'h3);
      go(4'h2);
      rd(dp_host_pkg::REG_RDATA, rd_v);
      `CHK(rd_v[8:0], 9'h000)
      acc(5'h00, 32'h1, 4'h3);
      go(4'h2);
      rd(dp_host_pkg::REG_RDATA, rd_v);
      `CHK(rd_v[8:0], 9'h1FF)
      wrap_up;
   end
endmodule
